// File: design/pcrc_top.sv
// Programmable CRC generator: configurable order and term mask, one bit per clock.
`timescale 1ns/1ps
// How it works
// - Orders up to 32 are supported with up to 32 shift stages.
// - Order select holds order minus one; 0x0F gives 16, 0x1F gives 32.
// - Term mask is two 16-bit halves: high covers 31..16, low 15..0.
// - A set mask bit applies feedback XOR at that stage; cleared applies none.
// - Constant term always feeds back; mask bit zero is ignored.
// - Top term of order N is always present, no mask bit needed.
module pcrc_top #(
  parameter int MAX_ORDER = pcrc_pkg::PCRC_MAX_ORDER
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Configuration
  input wire pcrc_pkg::pcrc_cfg_s cfg,
  input wire logic clear,
  // Serial data in
  input wire pcrc_pkg::pcrc_bit_s din,
  // Result
  output logic [MAX_ORDER-1:0] crc_result,
  output logic crc_valid,
  output logic busy
);
  import pcrc_pkg::*;

  // Two flops so every stage leaves reset on one clean edge
  logic [PCRC_SYNC_STAGES-1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[PCRC_SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[PCRC_SYNC_STAGES-1];

  logic [PCRC_LEN_W-1:0] len_q, len_d;
  logic [MAX_ORDER-1:0] mask_q, mask_d;
  logic [MAX_ORDER-1:0] rem_q, rem_d;
  logic [MAX_ORDER-1:0] rem_shift;
  logic [MAX_ORDER-1:0] range_v;
  logic [MAX_ORDER-1:0] taps;
  logic valid_d;
  logic busy_d;
  pcrc_state_e st_q, st_d;
  logic fb;

  // Order register and mask; changing order mid-stream is allowed but restarts nothing
  always_comb begin
    len_d = cfg.poly_order_select;
    mask_d = {cfg.term_mask_high, cfg.term_mask_low};
  end

  always_comb begin
    for (int i = 0; i < MAX_ORDER; i++) begin
      range_v[i] = (i <= int'(len_q));
    end
  end

  // Feedback leaves the top stage of the programmed order
  always_comb begin
    fb = rem_q[len_q] ^ din.data;
    taps = mask_q;
    taps[0] = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < MAX_ORDER; g++) begin : g_stage
      if (g == 0) begin : g_first
        pcrc_stage u_stage (
          .prev_bit(1'b0),
          .fb(fb),
          .tap_en(taps[0]),
          .in_range(range_v[0]),
          .next_bit(rem_shift[0])
        );
      end else begin : g_rest
        pcrc_stage u_stage (
          .prev_bit(rem_q[g-1]),
          .fb(fb),
          .tap_en(taps[g]),
          .in_range(range_v[g]),
          .next_bit(rem_shift[g])
        );
      end
    end
  endgenerate

  always_comb begin
    rem_d = rem_q;
    valid_d = 1'b0;
    st_d = st_q;
    case (st_q)
      PCRC_IDLE: begin
        if (din.valid) begin
          rem_d = rem_shift;
          valid_d = 1'b1;
          st_d = PCRC_RUN;
        end
      end
      PCRC_RUN: begin
        if (din.valid) begin
          rem_d = rem_shift;
          valid_d = 1'b1;
        end else begin
          st_d = PCRC_IDLE;
        end
      end
      default: begin
        st_d = PCRC_IDLE;
      end
    endcase
    // Clear takes priority so software can restart with a fresh seed
    if (clear) begin
      rem_d = PCRC_REM_RST;
      valid_d = 1'b0;
      st_d = PCRC_IDLE;
    end
  end

  // Busy follows the state about to be entered so it lines up with the result
  always_comb begin
    busy_d = (st_d == PCRC_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= PCRC_LEN_RST;
      mask_q <= {PCRC_MASK_HI_RST, PCRC_MASK_LO_RST};
      rem_q <= PCRC_REM_RST;
      st_q <= PCRC_IDLE;
    end else begin
      len_q <= len_d;
      mask_q <= mask_d;
      rem_q <= rem_d;
      st_q <= st_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_result <= PCRC_REM_RST;
      crc_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      crc_result <= rem_d;
      crc_valid <= valid_d;
      busy <= busy_d;
    end
  end

  // Assertions
  // Stage range and order decode
  top_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear) |=> ((rem_q & ~$past(range_v)) == '0))
    else $error("stage above order not cleared");
  top_stage_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear && len_q == PCRC_LEN_32) |->
      rem_d[31] == (rem_q[30] ^ ((rem_q[31] ^ din.data) & mask_q[31])))
    else $error("top stage of order 32 wrong");
  order_used_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (len_q == PCRC_LEN_16) |-> !range_v[16] && range_v[15])
    else $error("order 16 range wrong");
  order_full_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (len_q == PCRC_LEN_32) |-> (&range_v))
    else $error("order 32 range wrong");
  order_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $countones(range_v) == int'(len_q) + 1)
    else $error("stage count differs from order");

  // Mask capture; the first edge out of reset still shows the reset mask
  mask_split_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n |=> mask_q[31:16] == $past(cfg.term_mask_high))
    else $error("high mask half misplaced");
  mask_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rst_n |=> mask_q[15:0] == $past(cfg.term_mask_low))
    else $error("low mask half misplaced");

  // Feedback network, checked against a plain shift-and-xor
  tap_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear && fb && len_q == PCRC_LEN_32) |->
      rem_d[5] == (rem_q[4] ^ mask_q[5]))
    else $error("tap xor wrong");
  const_term_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear) |-> rem_d[0] == (rem_q[len_q] ^ din.data))
    else $error("constant term missing");
  top_term_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear && (rem_q[len_q] ^ din.data)) |-> rem_d[0])
    else $error("top term not used");
  shift_plain_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear && !(rem_q[len_q] ^ din.data)) |->
      rem_d == ((rem_q << 1) & range_v))
    else $error("plain shift wrong");
  shift_fb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear && (rem_q[len_q] ^ din.data)) |->
      rem_d == (((rem_q << 1) ^ {mask_q[MAX_ORDER-1:1], 1'b1}) & range_v))
    else $error("feedback shift wrong");

  // Output timing and clear
  valid_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (din.valid && !clear) |=> crc_valid && busy)
    else $error("valid or busy missing after bit");
  valid_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!din.valid || clear) |=> !crc_valid)
    else $error("valid without bit");
  busy_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!din.valid || clear) |=> !busy)
    else $error("busy without bit");
  clear_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clear |=> (crc_result == '0) && !busy && !crc_valid)
    else $error("clear did not win");
  result_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!din.valid && !clear) |=> crc_result == $past(crc_result))
    else $error("result moved without data");
  shift_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!din.valid && !clear) |=> rem_q == $past(rem_q))
    else $error("remainder changed without data");
endmodule

// File: design/pcrc_pkg.sv
// Package for the programmable CRC generator: widths, reset values, carriers.
package pcrc_pkg;

  localparam int PCRC_MAX_ORDER = 32;
  localparam int PCRC_LEN_W = 5;
  localparam int PCRC_HALF_W = 16;
  localparam logic [PCRC_LEN_W-1:0] PCRC_LEN_16 = 5'h0F;
  localparam logic [PCRC_LEN_W-1:0] PCRC_LEN_32 = 5'h1F;
  localparam logic [PCRC_LEN_W-1:0] PCRC_LEN_RST = 5'h0F;
  localparam logic [PCRC_HALF_W-1:0] PCRC_MASK_HI_RST = 16'h0000;
  localparam logic [PCRC_HALF_W-1:0] PCRC_MASK_LO_RST = 16'h1020;
  localparam logic [PCRC_MAX_ORDER-1:0] PCRC_REM_RST = 32'h0000_0000;
  localparam int PCRC_SYNC_STAGES = 2;

  typedef struct packed {
    logic [PCRC_LEN_W-1:0] poly_order_select;
    logic [PCRC_HALF_W-1:0] term_mask_high;
    logic [PCRC_HALF_W-1:0] term_mask_low;
  } pcrc_cfg_s;

  typedef struct packed {
    logic valid;
    logic data;
  } pcrc_bit_s;

  typedef enum logic [1:0] {
    PCRC_IDLE,
    PCRC_RUN
  } pcrc_state_e;

endpackage

// File: design/pcrc_stage.sv
// One shift stage of the CRC register with optional feedback tap.
`timescale 1ns/1ps
module pcrc_stage (
  // Neighbour and feedback
  input wire logic prev_bit,
  input wire logic fb,
  // Controls
  input wire logic tap_en,
  input wire logic in_range,
  // Result
  output logic next_bit
);
  always_comb begin
    // Stages above the order stay cleared so a shorter order reads cleanly
    if (!in_range) begin
      next_bit = 1'b0;
    end else begin
      next_bit = prev_bit ^ (fb & tap_en);
    end
  end
endmodule

// File: bench/pcrc_top_bench.sv
// Self-checking bench for the programmable CRC generator.
`timescale 1ns/1ps
module pcrc_top_bench;
  import pcrc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clear = 1'b0;
  pcrc_cfg_s cfg = '0;
  pcrc_bit_s din = '0;
  logic [31:0] crc_result;
  logic crc_valid;
  logic busy;
  logic [31:0] exp_rem;
  int err_count = 0;
  int checks = 0;
  pcrc_top DUT (.core_clk(core_clk), .rstn(rstn), .cfg(cfg), .clear(clear), .din(din),
    .crc_result(crc_result), .crc_valid(crc_valid), .busy(busy));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Reference step; constant term forced, stages above the order cleared
  function automatic logic [31:0] step(input logic [31:0] r, input logic d);
    logic fb;
    logic [31:0] m;
    int n;
    n = int'(cfg.poly_order_select) + 1;
    m = {cfg.term_mask_high, cfg.term_mask_low[15:1], 1'b1};
    fb = r[n-1] ^ d;
    r = (r << 1) ^ (m & {32{fb}});
    return r & 32'((64'h1 << n) - 64'h1);
  endfunction
  // Program, clear, stream bits back to back; each answer checked as it lands
  task automatic run(input logic [4:0] os, input logic [31:0] m, input logic [31:0] msg,
      input int nb);
    @(posedge core_clk);
    cfg <= {os, m};
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    exp_rem = '0;
    for (int i = nb; i >= 0; i--) begin
      @(posedge core_clk);
      din <= {i > 0, msg[(i + 31) % 32]};
      #1;
      if (i < nb) begin
        chk(crc_result, exp_rem);
        chk(crc_valid, 1'b1);
        chk(busy, 1'b1);
      end
      if (i > 0) exp_rem = step(exp_rem, msg[i - 1]);
    end
    @(posedge core_clk);
    #1;
    chk(crc_valid, 1'b0);
    chk(busy, 1'b0);
    chk(crc_result, exp_rem);
  endtask
  task automatic sc_reset();
    #1;
    chk(crc_result, 32'h0000_0000);
    chk(crc_valid, 1'b0);
    chk(busy, 1'b0);
  endtask
  // Reset in mid-stream drops the remainder; the block then restarts cleanly
  task automatic sc_reset_mid();
    @(posedge core_clk);
    cfg <= {5'h1F, 32'h04C1_1DB7};
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    din <= 2'h3;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b0;
    din <= 2'h0;
    #1;
    chk(crc_result, 32'h0000_0000);
    chk(crc_valid, 1'b0);
    chk(busy, 1'b0);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(crc_result, 32'h0000_0000);
    chk(busy, 1'b0);
    run(5'h0F, 32'h0000_1021, 32'h0000_5A5A, 16);
  endtask
  // Mask bit zero set or cleared must give the same remainder
  task automatic sc_order16();
    run(5'h0F, 32'h0000_1020, 32'h3132_3334, 32);
    run(5'h0F, 32'h0000_1021, 32'h3132_3334, 32);
  endtask
  task automatic sc_order32();
    run(5'h1F, 32'h04C1_1DB7, 32'hDEAD_BEEF, 32);
    run(5'h1F, 32'h8001_0000, 32'hF00F_5AA5, 32);
  endtask
  // Mask bits above a short order must have no effect
  task automatic sc_short();
    run(5'h07, 32'hFFFF_FF07, 32'h0000_00A5, 8);
    run(5'h00, 32'hFFFF_FFFF, 32'h0000_00B3, 8);
  endtask
  // Clear beats a bit offered in the same cycle
  task automatic sc_clear();
    run(5'h0F, 32'h0000_1021, 32'h0000_00C3, 8);
    @(posedge core_clk);
    clear <= 1'b1;
    din <= 2'h3;
    @(posedge core_clk);
    clear <= 1'b0;
    din <= 2'h0;
    #1;
    chk(crc_result, 32'h0000_0000);
    chk(crc_valid, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    sc_reset();
    sc_order16();
    sc_order32();
    sc_short();
    sc_clear();
    sc_reset_mid();
    give_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end
endmodule
